// file: logic/uhp_consts.vh
`ifndef UHP_CONSTS_VH
`define UHP_CONSTS_VH
// ============================================================
// register byte addresses
`define UHP_OFF_FRAME_NUMBER      12'h420
`define UHP_OFF_PRST      12'h41c
`define UHP_OFF_ADDR_LO   12'h424
`define UHP_OFF_ADDR_HI   12'h428
`define UHP_OFF_CFG_BASE  12'h500
`define UHP_OFF_STA_BASE  12'h530
`define UHP_OFF_EVT       12'h5a0
`define UHP_OFF_BUSRST    12'h5a4
// ============================================================
// frame timing
`define UHP_SOF_PERIOD_MS 1
`define UHP_FRAME_CLK_HZ  12000000
`define UHP_FRAME_LEN     14'h2ee0
`define UHP_FRAME_LAST    14'h2edf
// ============================================================
// configuration field positions
`define UHP_CFG_MEMORY_ALLOCATE     1
`define UHP_CFG_PBK_LO    2
`define UHP_CFG_BANK_SIZE_CODE_LO  4
`define UHP_CFG_TOK_LO    8
`define UHP_CFG_AUTO_BANK_SWITCH    10
`define UHP_CFG_TYPE_LO   12
`define UHP_CFG_EP_LO     16
`define UHP_CFG_POLL_LO   24
// field masks: writable / kept through pipe reset / through disable
`define UHP_CFG_WMASK     32'hff0f377e
`define UHP_CFG_KEEP_RST  32'hff0f337e
`define UHP_CFG_KEEP_DIS  32'h0000007e
// ============================================================
// status field positions
`define UHP_STA_CONFIG_VALID     18
`define UHP_STA_FIFO_ACCESS_ALLOWED     16
`define UHP_STA_BYCT_LO   20
`define UHP_STA_DT_LO     8
// ============================================================
// pipe kinds, tokens
`define UHP_KIND_CTRL     2'h0
`define UHP_KIND_ISO      2'h1
`define UHP_KIND_BULK     2'h2
`define UHP_KIND_INTR     2'h3
`define UHP_TOK_SETUP     2'h0
`define UHP_TOK_IN        2'h1
`define UHP_TOK_OUT       2'h2
`define UHP_PIPES         7
`endif

// file: logic/uhp_pipe_config.v
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
//
// Contract
// RULE1: 14-bit frame counter at 12 MHz, 12000 counts, SOF every 1 ms.
// RULE2: upper eight frame counter bits readable as frame length.
// RULE3: frame number field holds current SOF number, writable.
// RULE4: seven per-pipe device addresses in two registers drive transactions.
// RULE5: USB bus reset request clears all pipe device addresses.
// RULE6: pipe reset clears registers but keeps allocation and configuration fields; code also clears the auto bank switch bit.
// RULE7: pipe reset clears FIFO counter, keeps toggle, pipe stays enabled.
// RULE8: FIFO unusable until software writes zero to pipe reset bit.
// RULE9: writing one to enable bit in bits 6:0 enables the pipe.
// RULE10: disabling resets pipe registers, keeps allocate, bank count, size.
// RULE11: poll period is interrupt-pipe maximum poll interval in ms.
// RULE12: each pipe targets endpoint from its endpoint field, 0 to 15.
// RULE13: pipe kind 00 control, 01 iso, 10 bulk, 11 interrupt.
// RULE14: auto bank switch bit enables automatic bank switching.
// RULE15: token 00 SETUP, 01 IN, 10 OUT, 11 reserved.
// RULE16: bank size code gives 8 to 1024 bytes, power of two.
// RULE17: bank count 00 one, 01 two, 10 three, 11 reserved.
// RULE18: software should give control pipes one bank.
// RULE19: USB bus reset clears poll, endpoint, kind, autoswitch, size, count.
// RULE20: allocate bit reserves or frees memory, cleared by USB reset.
// RULE21: status holds byte count, config ok, access, bank, toggle, flags.
// RULE22: reserved bits read zero; writes to them and status ignored.
`include "uhp_consts.vh"

module uhp_pipe_config #(
    parameter CLK_HZ   = 100000000,
    parameter MAX_BANK = 2
) (
    // clock and reset
    input  wire        clock,
    input  wire        reset_n,
    // register port
    input  wire [11:0] regAddr,
    input  wire [31:0] regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdData,
    // pipe engine status inputs (same clock)
    input  wire [76:0] pipeByteCount,
    input  wire [13:0] pipeToggle,
    input  wire [13:0] pipeCurBank,
    input  wire [13:0] pipeBusyBanks,
    input  wire [55:0] pipeEvents,
    // pipe engine controls
    output reg  [6:0]  pipeActive,
    output reg  [6:0]  fifoUsable,
    output reg  [6:0]  pipeMechReset,
    output reg         sofPulse,
    output reg  [10:0] frameNumber,
    output reg  [48:0] pipeDevAddr,
    output reg  [27:0] pipeEndpoint,
    output reg  [13:0] pipeToken,
    output reg  [13:0] pipeKind,
    output reg  [6:0]  pipeAutoSwitch,
    output reg  [6:0]  pollDue
);

// ============================================================
// timebase: 12 MHz tick from a phase accumulator
localparam [31:0] TICK_INC = `UHP_FRAME_CLK_HZ;
localparam [31:0] TICK_MOD = CLK_HZ;

reg  [31:0] phaseReg;
reg  [13:0] frameCntReg;
reg         busRstReg;
wire [32:0] phaseSum = {1'b0, phaseReg} + {1'b0, TICK_INC};
wire        tick     = (phaseSum >= {1'b0, TICK_MOD});

// frame counter and frame number
always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        phaseReg    <= 32'h0;
        frameCntReg <= 14'h0;
        frameNumber <= 11'h0;
        sofPulse    <= 1'b0;
    end else begin
        sofPulse <= 1'b0;
        phaseReg <= tick ? phaseSum[31:0] - TICK_MOD : phaseSum[31:0];
        if (tick) begin
            if (frameCntReg == `UHP_FRAME_LAST) begin // see RULE1
                frameCntReg <= 14'h0;
                sofPulse    <= 1'b1;
                frameNumber <= frameNumber + 11'h1;
            end else begin
                frameCntReg <= frameCntReg + 14'h1;
            end
        end
        if (regWr && regAddr == `UHP_OFF_FRAME_NUMBER)
            frameNumber <= regWrData[13:3]; // see RULE3
    end
end

// ============================================================
// enable/reset register and addresses
reg [6:0]  penReg;
reg [6:0]  prstReg;
reg [31:0] addrLoReg;
reg [31:0] addrHiReg;

always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        penReg    <= 7'h0;
        prstReg   <= 7'h0;
        addrLoReg <= 32'h0;
        addrHiReg <= 32'h0;
        busRstReg <= 1'b0;
    end else begin
        busRstReg <= regWr && regAddr == `UHP_OFF_BUSRST && regWrData[0];
        if (regWr && regAddr == `UHP_OFF_PRST) begin
            penReg  <= regWrData[6:0];   // see RULE9
            prstReg <= regWrData[22:16]; // see RULE8
        end
        if (busRstReg) begin
            addrLoReg <= 32'h0; // see RULE5
            addrHiReg <= 32'h0;
        end else if (regWr && regAddr == `UHP_OFF_ADDR_LO) begin
            addrLoReg <= regWrData & 32'h7f7f7f7f; // see RULE22
        end else if (regWr && regAddr == `UHP_OFF_ADDR_HI) begin
            addrHiReg <= regWrData & 32'h007f7f7f;
        end
    end
end

// ============================================================
// per-pipe configuration, derived controls and readback
reg  [31:0] cfgReg  [0:6];
reg  [9:0]  pollCnt [0:6];
wire [31:0] staWord [0:6];

// bank count code legal for this build
function config_valid;
    input [31:0] c;
    begin
        config_valid = (c[`UHP_CFG_PBK_LO+1:`UHP_CFG_PBK_LO] < MAX_BANK); // see RULE17
    end
endfunction

genvar p;
generate
    for (p = 0; p < `UHP_PIPES; p = p + 1) begin : gPipe
        wire cfgHit = regWr && regAddr == `UHP_OFF_CFG_BASE + 4 * p;
        // clears act on the enable/reset write, so a disabled pipe
        // can still be configured before it is enabled
        wire prstHit = regWr && regAddr == `UHP_OFF_PRST;
        wire [31:0] c = cfgReg[p];
        // status word assembly
        assign staWord[p] = {1'b0, pipeByteCount[11*p+10:11*p],
            1'b0, config_valid(c) & c[`UHP_CFG_MEMORY_ALLOCATE], 1'b0,
            fifoUsable[p], pipeCurBank[2*p+1:2*p],
            pipeBusyBanks[2*p+1:2*p], 2'b00,
            pipeToggle[2*p+1:2*p],
            pipeEvents[8*p+7:8*p]}; // see RULE21

        // config register with reset, disable and bus reset clears
        always @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                cfgReg[p] <= 32'h0;
            end else if (busRstReg) begin
                cfgReg[p] <= 32'h0; // see RULE19 see RULE20
            end else if (cfgHit) begin
                cfgReg[p] <= regWrData & `UHP_CFG_WMASK; // see RULE22
            end else if (prstHit && !regWrData[p]) begin
                cfgReg[p] <= c & `UHP_CFG_KEEP_DIS; // see RULE10
            end else if (prstHit && regWrData[16+p]) begin
                cfgReg[p] <= c & `UHP_CFG_KEEP_RST; // see RULE6
            end
        end

        // outputs per pipe and interrupt poll timer
        always @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                pipeActive[p]            <= 1'b0;
                fifoUsable[p]            <= 1'b0;
                pipeMechReset[p]         <= 1'b0;
                pipeDevAddr[7*p+6:7*p]   <= 7'h0;
                pipeEndpoint[4*p+3:4*p]  <= 4'h0;
                pipeToken[2*p+1:2*p]     <= 2'h0;
                pipeKind[2*p+1:2*p]      <= 2'h0;
                pipeAutoSwitch[p]        <= 1'b0;
                pollDue[p]               <= 1'b0;
                pollCnt[p]               <= 10'h0;
            end else begin
                pipeActive[p]    <= penReg[p]; // see RULE7
                pipeMechReset[p] <= prstReg[p] | ~penReg[p]; // see RULE7
                fifoUsable[p]    <= penReg[p] & ~prstReg[p]
                                    & c[`UHP_CFG_MEMORY_ALLOCATE]
                                    & config_valid(c); // see RULE8
                pipeDevAddr[7*p+6:7*p] <= (p < 4)
                    ? addrLoReg[8*(p%4)+6:8*(p%4)]
                    : addrHiReg[8*(p%4)+6:8*(p%4)]; // see RULE4
                pipeEndpoint[4*p+3:4*p] <=
                    c[`UHP_CFG_EP_LO+3:`UHP_CFG_EP_LO]; // see RULE12
                pipeToken[2*p+1:2*p] <=
                    c[`UHP_CFG_TOK_LO+1:`UHP_CFG_TOK_LO]; // see RULE15
                pipeKind[2*p+1:2*p] <=
                    c[`UHP_CFG_TYPE_LO+1:`UHP_CFG_TYPE_LO]; // see RULE13
                pipeAutoSwitch[p] <= c[`UHP_CFG_AUTO_BANK_SWITCH]; // see RULE14
                // poll due once the period elapses, interrupt pipes only
                pollDue[p] <= 1'b0;
                if (c[`UHP_CFG_TYPE_LO+1:`UHP_CFG_TYPE_LO] != `UHP_KIND_INTR
                    || !penReg[p]) begin
                    pollCnt[p] <= 10'h0; // see RULE11
                end else if (sofPulse) begin
                    if (pollCnt[p] + 10'h1 >=
                        {2'b00, c[31:`UHP_CFG_POLL_LO]}) begin
                        pollCnt[p] <= 10'h0;
                        pollDue[p] <= 1'b1; // see RULE11
                    end else begin
                        pollCnt[p] <= pollCnt[p] + 10'h1;
                    end
                end
            end
        end
    end
endgenerate

// bank size in bytes from the size code
function [10:0] bankBytes;
    input [2:0] code;
    begin
        bankBytes = 11'h8 << code; // see RULE16
    end
endfunction

// ============================================================
// read decode, data one cycle after strobe
reg [31:0] rdNext;
reg [11:0] off;
always @* begin
    rdNext = 32'h0;
    off    = 12'h0;
    if (regAddr == `UHP_OFF_FRAME_NUMBER) begin
        rdNext = {8'h0, frameCntReg[13:6], 2'b00, frameNumber,
                  3'b000}; // see RULE2
    end else if (regAddr == `UHP_OFF_PRST) begin
        rdNext = {9'h0, prstReg, 9'h0, penReg};
    end else if (regAddr == `UHP_OFF_ADDR_LO) begin
        rdNext = addrLoReg;
    end else if (regAddr == `UHP_OFF_ADDR_HI) begin
        rdNext = addrHiReg;
    end else if (regAddr >= `UHP_OFF_CFG_BASE &&
                 regAddr < `UHP_OFF_CFG_BASE + 12'h1c &&
                 regAddr[1:0] == 2'b00) begin
        off    = regAddr - `UHP_OFF_CFG_BASE;
        rdNext = cfgReg[off[4:2]];
    end else if (regAddr >= `UHP_OFF_STA_BASE &&
                 regAddr < `UHP_OFF_STA_BASE + 12'h1c &&
                 regAddr[1:0] == 2'b00) begin
        off    = regAddr - `UHP_OFF_STA_BASE;
        rdNext = staWord[off[4:2]]; // see RULE22
    end else if (regAddr == `UHP_OFF_EVT) begin
        off    = 12'h0;
        rdNext = {21'h0, bankBytes(cfgReg[0][6:4])};
    end
end

always @(posedge clock or negedge reset_n) begin
    if (!reset_n)
        regRdData <= 32'h0;
    else
        regRdData <= regRd ? rdNext : 32'h0;
end

endmodule // uhp_pipe_config

// file: verif/uhp_pipe_config_chk.sv
`timescale 1ns/10ps
`include "uhp_consts.vh"
// ============================================================
// port-level checker of the pipe configuration block
module uhp_pipe_config_chk #(
    parameter CLK_HZ   = 100000000,
    parameter MAX_BANK = 2
) (
    // clock, reset and register port
    input logic        clock,
    input logic        reset_n,
    input logic [11:0] regAddr,
    input logic [31:0] regWrData,
    input logic        regWr,
    input logic        regRd,
    input logic [31:0] regRdData,
    // pipe engine controls
    input logic [6:0]  pipeActive,
    input logic [6:0]  fifoUsable,
    input logic [6:0]  pipeMechReset,
    input logic        sofPulse,
    input logic [48:0] pipeDevAddr,
    input logic [27:0] pipeEndpoint,
    input logic [13:0] pipeKind,
    input logic [6:0]  pollDue
);
    localparam int GAP = CLK_HZ / 1000;
    int         gap;
    logic       seen;
    logic [6:0] intr;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // cycles since last frame start; any write restarts the watch
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            gap  <= 0;
            seen <= 1'b0;
        end else begin
            gap  <= sofPulse ? 1 : gap + 1;
            seen <= (seen | sofPulse) & ~regWr;
        end
    end
    // pipes configured as interrupt kind
    always_comb for (int i = 0; i < 7; i++)
        intr[i] = pipeKind[2*i+:2] == `UHP_KIND_INTR;
    AST_SOF_ONE: assert property (sofPulse |=> !sofPulse)
        else $error("frame start pulse too long");
    AST_SOF_GAP: assert property (sofPulse && seen |-> gap == GAP)
        else $error("frame period wrong");
    AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data outside read cycle");
    AST_UNMAP: assert property (regRd && regAddr == 12'h0 |=>
        regRdData == 32'h0) else $error("unmapped read not zero");
    AST_ENABLE: assert property (regWr && regAddr == `UHP_OFF_PRST |->
        ##2 pipeActive == $past(regWrData[6:0], 2)) else $error("enable lost");
    AST_OFF_MECH: assert property ($past(reset_n, 2) && $stable(pipeActive)
        |-> (pipeActive | pipeMechReset) == 7'h7f) else $error("idle pipe live");
    AST_USABLE: assert property ($stable(pipeActive) && $stable(pipeMechReset)
        |-> (fifoUsable & (~pipeActive | pipeMechReset)) == 7'h0)
        else $error("fifo usable in reset or disabled");
    AST_BUS_RESET: assert property (regWr && regAddr == `UHP_OFF_BUSRST
        && regWrData[0] |-> ##[3:4] (pipeDevAddr == 49'h0
        && pipeEndpoint == 28'h0 && pipeKind == 14'h0))
        else $error("bus reset left fields set");
    AST_POLL: assert property ($stable(pipeKind) && $stable(pipeActive)
        |-> (pollDue & ~(intr & pipeActive)) == 7'h0)
        else $error("poll on non-interrupt pipe");
    CV_SOF: cover property (sofPulse);
    CV_POLL: cover property (|pollDue);
    CV_PRST: cover property (|(pipeMechReset & pipeActive));
endmodule // uhp_pipe_config_chk

bind uhp_pipe_config uhp_pipe_config_chk #(
    .CLK_HZ(CLK_HZ), .MAX_BANK(MAX_BANK)) u_chk (
    .clock, .reset_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .pipeActive, .fifoUsable, .pipeMechReset, .sofPulse, .pipeDevAddr,
    .pipeEndpoint, .pipeKind, .pollDue);

// file: verif/uhp_engine_model.sv
`timescale 1ns/10ps
// ============================================================
// far-side pipe engine: counts traffic once per frame
module uhp_engine_model (
    input  logic        clock,
    input  logic        reset_n,
    input  logic [6:0]  pipeMechReset,
    input  logic [6:0]  fifoUsable,
    input  logic        sofPulse,
    output logic [76:0] pipeByteCount,
    output logic [13:0] pipeToggle,
    output logic [13:0] pipeCurBank,
    output logic [13:0] pipeBusyBanks,
    output logic [55:0] pipeEvents
);
    // fixed bank and event patterns shown in status
    assign pipeCurBank   = 14'h2d39;
    assign pipeBusyBanks = 14'h1596;
    assign pipeEvents    = 56'h5ac3e1970f2b84;
    // byte count cleared by pipe reset, toggle kept through it
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pipeByteCount <= '0;
            pipeToggle    <= '0;
        end else for (int i = 0; i < 7; i++) begin
            if (pipeMechReset[i]) pipeByteCount[11*i+:11] <= '0;
            else if (sofPulse && fifoUsable[i])
                pipeByteCount[11*i+:11] <= pipeByteCount[11*i+:11] + 11'h1;
            if (sofPulse && fifoUsable[i]) pipeToggle[2*i] <= ~pipeToggle[2*i];
        end
    end
endmodule // uhp_engine_model

// file: verif/uhp_pipe_config_test.sv
`timescale 1ns/10ps
`include "uhp_consts.vh"
// ============================================================
// self-checking bench of the pipe configuration block
module uhp_pipe_config_test;
    logic clock, reset_n, regWr, regRd, sofPulse;
    logic [11:0] regAddr;
    logic [31:0] regWrData, regRdData, d, cfg [7];
    logic [48:0] expAddr, pipeDevAddr;
    logic [76:0] pipeByteCount;
    logic [13:0] pipeToggle, pipeCurBank, pipeBusyBanks, pipeToken, pipeKind;
    logic [55:0] pipeEvents;
    logic [6:0]  pipeActive, fifoUsable, pipeMechReset, pipeAutoSwitch;
    logic [6:0]  pollDue, usable;
    logic [10:0] frameNumber;
    logic [27:0] pipeEndpoint;
    int          failCount, compares, n;
    uhp_pipe_config #(.CLK_HZ(12000000)) u_dut (.clock, .reset_n, .regAddr,
        .regWrData, .regWr, .regRd, .regRdData, .pipeByteCount, .pipeToggle,
        .pipeCurBank, .pipeBusyBanks, .pipeEvents, .pipeActive, .fifoUsable,
        .pipeMechReset, .sofPulse, .frameNumber, .pipeDevAddr, .pipeEndpoint,
        .pipeToken, .pipeKind, .pipeAutoSwitch, .pollDue);
    uhp_engine_model u_dev (.clock, .reset_n, .pipeMechReset, .fifoUsable,
        .sofPulse, .pipeByteCount, .pipeToggle, .pipeCurBank, .pipeBusyBanks,
        .pipeEvents);
    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // bus cycles, comparisons and the closing report
    task automatic chk(input string s, input logic [63:0] e, g);
        compares++;
        if (g !== e) begin
            failCount++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clock);
        regAddr   <= a;
        regWrData <= v;
        regWr     <= 1'b1;
        @(posedge clock);
        regWr     <= 1'b0;
        #1;
    endtask
    task automatic rdChk(input string s, input logic [11:0] a, logic [31:0] e);
        @(posedge clock);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clock);
        regRd   <= 1'b0;
        #1 d = regRdData;
        chk(s, e, d);
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic waitSof(output int c);
        c = 0;
        do begin
            @(posedge clock);
            #1 c++;
        end while (!sofPulse && c < 13000);
        if (c >= 13000) begin
            failCount++;
            summarize();
        end
    endtask
    // expected status word of pipe k
    function automatic logic [31:0] stat(int k);
        return {1'b0, pipeByteCount[11*k+:11], 1'b0, cfg[k][1] & ~cfg[k][3],
            1'b0, usable[k], pipeCurBank[2*k+:2], pipeBusyBanks[2*k+:2], 2'h0,
            pipeToggle[2*k+:2], pipeEvents[8*k+:8]};
    endfunction
    // main sequence
    initial begin
        {reset_n, regWr, regRd, regAddr, regWrData, failCount, compares} = '0;
        n = $urandom(7401);
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        rdChk("rstEn", `UHP_OFF_PRST, 32'h0);
        d = $urandom;
        for (int i = 0; i < 4; i++) expAddr[7*i+:7] = d[8*i+:7];
        wr(`UHP_OFF_ADDR_LO, d);
        rdChk("addrLo", `UHP_OFF_ADDR_LO, d & 32'h7f7f7f7f);
        d = $urandom;
        for (int i = 0; i < 3; i++) expAddr[28+7*i+:7] = d[8*i+:7];
        wr(`UHP_OFF_ADDR_HI, d);
        rdChk("addrHi", `UHP_OFF_ADDR_HI, d & 32'h007f7f7f);
        chk("devAddr", expAddr, pipeDevAddr);
        for (n = 0; n < 7; n++) begin
            d = $urandom & `UHP_CFG_WMASK;
            d[31:24] = {7'h0, d[24]};
            {d[13:12], d[9:8], d[1]} = {n[1:0], n[1:0], n != 6};
            if (n[1:0] == 2'h0) d[3:2] = 2'h0;
            cfg[n] = d;
            wr(`UHP_OFF_CFG_BASE + 12'(4*n), $urandom | 32'h00f0c081);
            wr(`UHP_OFF_CFG_BASE + 12'(4*n), d);
            rdChk("cfg", `UHP_OFF_CFG_BASE + 12'(4*n), d);
            chk("fields", {d[19:16], d[13:12], d[9:8], d[10]}, {pipeEndpoint[4*n+:4],
                pipeKind[2*n+:2], pipeToken[2*n+:2], pipeAutoSwitch[n]});
            usable[n] = d[1] & ~d[3];
        end
        rdChk("bankBytes", `UHP_OFF_EVT, 32'h8 << cfg[0][6:4]);
        wr(`UHP_OFF_PRST, 32'h7f);
        @(posedge clock);
        #1 chk("active", 7'h7f, pipeActive);
        waitSof(n);
        wr(`UHP_OFF_STA_BASE, 32'hffffffff);
        chk("usable", usable, fifoUsable);
        for (n = 0; n < 7; n++)
            rdChk("status", `UHP_OFF_STA_BASE + 12'(4*n), stat(n));
        waitSof(n);
        rdChk("flen", `UHP_OFF_FRAME_NUMBER, {18'h0, frameNumber, 3'h0});
        waitSof(n);
        waitSof(n);
        chk("period", 12000, n);
        rdChk("frame_number", `UHP_OFF_FRAME_NUMBER, {18'h0, d[13:3] + 11'h2, 3'h0});
        wr(`UHP_OFF_FRAME_NUMBER, 32'h3ff8);
        rdChk("fnumWr", `UHP_OFF_FRAME_NUMBER, 32'h3ff8);
        wr(`UHP_OFF_PRST, 32'h007f007f);
        for (n = 0; n < 7; n++) begin
            cfg[n] = cfg[n] & `UHP_CFG_KEEP_RST;
            rdChk("cfgRst", `UHP_OFF_CFG_BASE + 12'(4*n), cfg[n]);
        end
        chk("mech", 7'h7f, pipeMechReset & pipeActive);
        chk("noUse", 7'h0, fifoUsable);
        wr(`UHP_OFF_PRST, 32'h7f);
        repeat (2) @(posedge clock);
        #1 chk("reuse", usable, fifoUsable);
        wr(`UHP_OFF_PRST, 32'h0);
        for (n = 0; n < 7; n++) rdChk("cfgOff", `UHP_OFF_CFG_BASE + 12'(4*n),
            cfg[n] & `UHP_CFG_KEEP_DIS);
        rdChk("unmapped", 12'h0, 32'h0);
        wr(`UHP_OFF_BUSRST, 32'h1);
        repeat (4) @(posedge clock);
        rdChk("addrClr", `UHP_OFF_ADDR_LO, 32'h0);
        rdChk("cfgClr", `UHP_OFF_CFG_BASE, 32'h0);
        chk("devAddrClr", 49'h0, pipeDevAddr);
        summarize();
    end
endmodule // uhp_pipe_config_test
